/* design/bmpc_power_ctrl.sv */
// Battery monitor registers and low-power mode sequencer of the always-on domain
//
// Added by the designer: the strobed register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module bmpc_power_ctrl (
  input wire logic clk_sys,
  input wire logic srst,
  input wire bmpc_pkg::bmpc_req_s regReq,
  output logic [bmpc_pkg::DATA_W-1:0] regRdData,
  input wire logic battBelowLow,
  input wire logic battBelowUltra,
  input wire logic coreDeepSleep,
  input wire logic coreWaitReq,
  input wire logic ioRtcWake,
  input wire logic usbEthWake,
  output logic monitorRefOn,
  output logic [1:0] thresholdSelect,
  output logic lowIrqReq,
  output logic ultralowIrqReq,
  output logic nmiReq,
  output logic irq,
  output logic coreRun,
  output logic fastClkEn,
  output logic flashStandby,
  output logic flashOff,
  output logic mainRegOn,
  output logic dcdcBias,
  output logic dcdcEn,
  output bmpc_pkg::bmpc_ret_s retention,
  output logic wakeGlobalReset
);
  import bmpc_pkg::*;

  // Settle counts are fixed; a narrower timer would wrap and cut the wait short
  if (REG_SETTLE_CYC >= (1 << TMR_W) || CLK_SETTLE_CYC >= (1 << TMR_W)) begin : g_chk
    $error("Wake timer too narrow for the settle counts");
  end

  typedef struct packed {
    bmpc_state_e mode;
    logic [7:0] monCtrl;
    logic [1:0] thrSel;
    logic belowLow;
    logic belowUltra;
    logic [15:0] plan;
    logic [7:0] slpCfg;
    logic shutWakeFlag;
    logic [IRQ_N-1:0] irqStat;
    logic [IRQ_N-1:0] irqMask;
    logic [DATA_W-1:0] rdData;
    logic lowReq;
    logic ultraReq;
    logic nmi;
    logic irqOut;
    logic coreRun;
    logic fastClkEn;
    logic flashStandby;
    logic flashOff;
    logic mainRegOn;
    bmpc_ret_s ret;
    logic globalRst;
    logic [2:0] rstCnt;
  } bmpc_state_s;

  bmpc_state_s st;
  bmpc_state_s next_st;
  logic tmrLoad;
  logic [TMR_W-1:0] tmrCount;
  logic tmrDone;

  bmpc_wake_timer #(
    .CW(TMR_W)
  ) u_timer (
    .clk_sys(clk_sys),
    .srst(srst),
    .load(tmrLoad),
    .count(tmrCount),
    .done(tmrDone)
  );

  logic detEn;
  logic lowIe;
  logic ultraIe;
  logic batLowEvt;
  logic batUltraEvt;
  logic battWake;
  logic deepWake;
  logic shallowWake;
  logic [IRQ_N-1:0] irqSet;
  logic [IRQ_N-1:0] irqClr;
  logic planArmed;
  logic planSysOff;

  always_comb begin
    next_st = st;
    tmrLoad = 1'b0;
    tmrCount = '0;
    detEn = st.monCtrl[MON_EN_BIT];
    lowIe = st.monCtrl[LOW_IE_BIT];
    ultraIe = st.monCtrl[ULTRA_IE_BIT];
    planArmed = st.plan[PLAN_ARM_BIT];
    planSysOff = ~st.plan[PLAN_SYS_BIT];

    // Status flags read zero while detection is off, since the comparators are unpowered
    next_st.belowLow = detEn & battBelowLow;
    next_st.belowUltra = detEn & battBelowUltra;

    // Requests derive from the flags; ultra with both enables is promoted to NMI
    next_st.nmi = st.belowUltra & lowIe & ultraIe & detEn;
    next_st.lowReq = detEn & lowIe & st.belowLow;
    next_st.ultraReq = detEn & ultraIe & st.belowUltra & ~lowIe;
    battWake = st.lowReq | st.ultraReq | st.nmi;
    deepWake = battWake | ioRtcWake;
    shallowWake = deepWake | usbEthWake;

    batLowEvt = next_st.belowLow & ~st.belowLow;
    batUltraEvt = next_st.belowUltra & ~st.belowUltra;
    irqSet = '0;
    irqSet[IRQ_LOW_BIT] = batLowEvt;
    irqSet[IRQ_ULTRA_BIT] = batUltraEvt;
    irqClr = '0;

    // Register writes
    // Reserved bits other than plan bit 6 are dropped on write so they read back their reset values, which is one for plan bit 0
    if (regReq.wr) begin
      case (regReq.addr)
        OFS_MON_CTRL: begin
          next_st.monCtrl = {4'h0, regReq.wrData[LOW_IE_BIT], regReq.wrData[ULTRA_IE_BIT],
                             1'b0, regReq.wrData[MON_EN_BIT]};
        end
        OFS_THR_CFG: next_st.thrSel = regReq.wrData[THR_LSB +: 2];
        OFS_PWR_PLAN: begin
          next_st.plan = (regReq.wrData & PLAN_WR_MASK) | (PLAN_RESET & ~PLAN_WR_MASK);
        end
        OFS_SLP_CFG: next_st.slpCfg = regReq.wrData[7:0] & SLP_WR_MASK;
        OFS_RST_CAUSE: begin
          if (regReq.wrData[CAUSE_SHUT_WAKE_BIT]) begin
            next_st.shutWakeFlag = 1'b0;
          end
        end
        OFS_IRQ_STAT: irqClr = regReq.wrData[IRQ_N-1:0];
        OFS_IRQ_MASK: next_st.irqMask = regReq.wrData[IRQ_N-1:0];
        default: begin
        end
      endcase
    end

    // Mode sequencer
    case (st.mode)
      ST_RUN: begin
        if (coreWaitReq) begin
          next_st.coreRun = 1'b0;
          if (!coreDeepSleep) begin
            next_st.mode = ST_IDLE;
          end else if (planArmed && planSysOff) begin
            // Plan fields latch only here; later plan writes wait for the next entry
            next_st.ret.sysPower = 1'b0;
            next_st.ret.slowOsc = st.slpCfg[SLP_SLOW_OSC_BIT];
            next_st.ret.smallRam = st.plan[PLAN_SRAM_BIT];
            next_st.ret.largeRam = st.plan[PLAN_LRAM_BIT];
            next_st.plan[PLAN_ARM_BIT] = 1'b0;
            next_st.mainRegOn = 1'b0;
            next_st.fastClkEn = 1'b0;
            next_st.flashStandby = 1'b0;
            next_st.flashOff = 1'b1;
            if (st.plan[PLAN_CORE_BIT]) begin
              next_st.ret.extend = st.plan[PLAN_EXT_BIT];
              next_st.ret.coreKeep = 1'b1;
              next_st.mode = ST_SLEEP;
            end else begin
              next_st.ret.extend = 1'b0;
              next_st.ret.coreKeep = 1'b0;
              next_st.mode = ST_SHUT;
            end
          end else begin
            next_st.fastClkEn = 1'b0;
            next_st.flashOff = st.slpCfg[SLP_FLASH_OFF_BIT];
            next_st.flashStandby = ~st.slpCfg[SLP_FLASH_OFF_BIT];
            next_st.mode = ST_HALT;
          end
        end
      end
      ST_IDLE: begin
        // Clocks never stopped, so no settle wait is needed
        if (shallowWake) begin
          next_st.coreRun = 1'b1;
          next_st.mode = ST_RUN;
        end
      end
      ST_HALT: begin
        // Fast clocks get a settle time before the core may run again
        if (shallowWake) begin
          next_st.fastClkEn = 1'b1;
          next_st.flashOff = 1'b0;
          next_st.flashStandby = 1'b0;
          tmrLoad = 1'b1;
          tmrCount = TMR_W'(CLK_SETTLE_CYC);
          next_st.mode = ST_WAKE_CLK;
        end
      end
      ST_SLEEP: begin
        // USB and Ethernet wake are not honoured once the main regulator is off
        if (deepWake) begin
          next_st.mainRegOn = 1'b1;
          tmrLoad = 1'b1;
          tmrCount = TMR_W'(REG_SETTLE_CYC);
          next_st.mode = ST_WAKE_REG;
        end
      end
      ST_SHUT: begin
        // Always-on registers keep their values; only the rest of the chip is reset
        if (deepWake) begin
          next_st.mainRegOn = 1'b1;
          next_st.globalRst = 1'b1;
          next_st.rstCnt = 3'(RST_PULSE_CYC - 1);
          next_st.shutWakeFlag = 1'b1;
          irqSet[IRQ_SHUT_BIT] = 1'b1;
          next_st.mode = ST_WAKE_RST;
        end
      end
      ST_WAKE_REG: begin
        if (tmrDone) begin
          next_st.fastClkEn = 1'b1;
          next_st.flashOff = 1'b0;
          tmrLoad = 1'b1;
          tmrCount = TMR_W'(CLK_SETTLE_CYC);
          next_st.mode = ST_WAKE_CLK;
        end
      end
      ST_WAKE_CLK: begin
        if (tmrDone) begin
          next_st.coreRun = 1'b1;
          next_st.ret = '1;
          irqSet[IRQ_WAKE_BIT] = 1'b1;
          next_st.mode = ST_RUN;
        end
      end
      ST_WAKE_RST: begin
        // Pulse stands RST_PULSE_CYC cycles, counted down to zero
        if (st.rstCnt == 3'h0) begin
          next_st.globalRst = 1'b0;
          next_st.fastClkEn = 1'b1;
          next_st.flashOff = 1'b0;
          next_st.coreRun = 1'b1;
          next_st.ret = '1;
          next_st.mode = ST_RUN;
        end else begin
          next_st.rstCnt = st.rstCnt - 3'h1;
        end
      end
      default: next_st.mode = ST_RUN;
    endcase

    // Set wins over a same-cycle write-one clear
    next_st.irqStat = (st.irqStat & ~irqClr) | irqSet;
    next_st.irqOut = |(next_st.irqStat & next_st.irqMask);

    // Read data stands in the cycle after the strobe only
    next_st.rdData = '0;
    if (regReq.rd) begin
      case (regReq.addr)
        OFS_MON_CTRL: next_st.rdData = {8'h00, st.monCtrl};
        OFS_THR_CFG: next_st.rdData = {14'h0000, st.thrSel};
        OFS_MON_STAT: next_st.rdData = {14'h0000, st.belowLow, st.belowUltra};
        OFS_PWR_PLAN: next_st.rdData = st.plan;
        OFS_SLP_CFG: next_st.rdData = {8'h00, st.slpCfg};
        OFS_RST_CAUSE: next_st.rdData = {15'h0000, st.shutWakeFlag};
        OFS_IRQ_STAT: next_st.rdData = {12'h000, st.irqStat};
        OFS_IRQ_MASK: next_st.rdData = {12'h000, st.irqMask};
        OFS_MODE_STAT: next_st.rdData = {13'h0000, st.mode};
        default: next_st.rdData = '0;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st.mode <= ST_RUN;
      st.monCtrl <= 8'h00;
      st.thrSel <= THR_RESET;
      st.belowLow <= 1'b0;
      st.belowUltra <= 1'b0;
      st.plan <= PLAN_RESET;
      st.slpCfg <= SLP_RESET;
      st.shutWakeFlag <= 1'b0;
      st.irqStat <= '0;
      st.irqMask <= '0;
      st.rdData <= '0;
      st.lowReq <= 1'b0;
      st.ultraReq <= 1'b0;
      st.nmi <= 1'b0;
      st.irqOut <= 1'b0;
      st.coreRun <= 1'b1;
      st.fastClkEn <= 1'b1;
      st.flashStandby <= 1'b0;
      st.flashOff <= 1'b0;
      st.mainRegOn <= 1'b1;
      st.ret <= '1;
      st.globalRst <= 1'b0;
      st.rstCnt <= 3'h0;
    end else begin
      st <= next_st;
    end
  end

  assign regRdData = st.rdData;
  assign monitorRefOn = st.monCtrl[MON_EN_BIT];
  assign thresholdSelect = st.thrSel;
  assign lowIrqReq = st.lowReq;
  assign ultralowIrqReq = st.ultraReq;
  assign nmiReq = st.nmi;
  assign irq = st.irqOut;
  assign coreRun = st.coreRun;
  assign fastClkEn = st.fastClkEn;
  assign flashStandby = st.flashStandby;
  assign flashOff = st.flashOff;
  assign mainRegOn = st.mainRegOn;
  // DC-DC bits act at once, unlike the rest of the plan
  assign dcdcBias = st.plan[PLAN_DCDC_PRE_BIT];
  assign dcdcEn = st.plan[PLAN_DCDC_EN_BIT];
  assign retention = st.ret;
  assign wakeGlobalReset = st.globalRst;
endmodule
`default_nettype wire

/* design/bmpc_pkg.sv */
// Package of constants and carrier types for the battery monitor and power-mode controller
package bmpc_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;

  // Register offsets
  localparam logic [7:0] OFS_MON_CTRL = 8'h00;
  localparam logic [7:0] OFS_THR_CFG = 8'h01;
  localparam logic [7:0] OFS_MON_STAT = 8'h02;
  localparam logic [7:0] OFS_PWR_PLAN = 8'h03;
  localparam logic [7:0] OFS_SLP_CFG = 8'h04;
  localparam logic [7:0] OFS_RST_CAUSE = 8'h05;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h06;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h07;
  localparam logic [7:0] OFS_MODE_STAT = 8'h08;

  // Monitor control fields
  localparam int MON_EN_BIT = 0;
  localparam int ULTRA_IE_BIT = 2;
  localparam int LOW_IE_BIT = 3;
  // Threshold field and status fields
  localparam int THR_LSB = 0;
  localparam logic [1:0] THR_RESET = 2'h1;
  localparam int STAT_ULTRA_BIT = 0;
  localparam int STAT_LOW_BIT = 1;

  // Power plan fields
  localparam int PLAN_ARM_BIT = 15;
  localparam int PLAN_MUST_LSB = 11;
  localparam int PLAN_DCDC_PRE_BIT = 10;
  localparam int PLAN_DCDC_EN_BIT = 9;
  localparam int PLAN_LDO_BIT = 8;
  localparam int PLAN_SYS_BIT = 7;
  localparam int PLAN_RSV6_BIT = 6;
  localparam int PLAN_LRAM_BIT = 4;
  localparam int PLAN_EXT_BIT = 3;
  localparam int PLAN_CORE_BIT = 2;
  localparam int PLAN_SRAM_BIT = 1;
  localparam int PLAN_RSV0_BIT = 0;
  localparam logic [15:0] PLAN_WR_MASK = 16'hffde;
  localparam logic [15:0] PLAN_RESET = 16'h01df;

  // Sleep configuration fields
  localparam int SLP_FLASH_OFF_BIT = 3;
  localparam int SLP_SLOW_OSC_BIT = 4;
  localparam logic [7:0] SLP_WR_MASK = 8'h18;
  localparam logic [7:0] SLP_RESET = 8'h18;

  // Reset cause and interrupt status bits
  localparam int CAUSE_SHUT_WAKE_BIT = 0;
  localparam int IRQ_N = 4;
  localparam int IRQ_LOW_BIT = 0;
  localparam int IRQ_ULTRA_BIT = 1;
  localparam int IRQ_WAKE_BIT = 2;
  localparam int IRQ_SHUT_BIT = 3;

  // Wake-up timing
  localparam int CLK_PERIOD_PS = 4000;
  localparam int REG_SETTLE_NS = 2000;
  localparam int CLK_SETTLE_NS = 400;
  localparam int REG_SETTLE_CYC = (REG_SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CLK_SETTLE_CYC = (CLK_SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RST_PULSE_CYC = 4;
  localparam int TMR_W = 10;

  typedef enum logic [2:0] {
    ST_RUN, ST_IDLE, ST_HALT, ST_SLEEP, ST_SHUT, ST_WAKE_REG, ST_WAKE_CLK, ST_WAKE_RST
  } bmpc_state_e;

  // Domains kept alive during sleep or shutdown
  typedef struct packed {
    logic sysPower;
    logic slowOsc;
    logic smallRam;
    logic largeRam;
    logic extend;
    logic coreKeep;
  } bmpc_ret_s;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wrData;
    logic wr;
    logic rd;
  } bmpc_req_s;

endpackage

/* design/bmpc_wake_timer.sv */
// Down counter giving a one-cycle done pulse a loaded number of cycles after the load
`timescale 1ns/10ps
`default_nettype none
module bmpc_wake_timer #(
  parameter int CW = 10
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic load,
  input wire logic [CW-1:0] count,
  output logic done
);
  import bmpc_pkg::*;

  if (CW < 2) begin : g_chk
    $error("bmpc_wake_timer needs CW of at least 2");
  end

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic busy;
    logic done;
  } bmpc_tmr_s;

  bmpc_tmr_s st;
  bmpc_tmr_s next_st;

  always_comb begin
    next_st = st;
    next_st.done = 1'b0;
    if (load) begin
      next_st.cnt = count;
      next_st.busy = 1'b1;
    end else if (st.busy) begin
      // A count of one or less ends at once so a zero load cannot hang
      if (st.cnt <= CW'(1)) begin
        next_st.busy = 1'b0;
        next_st.done = 1'b1;
      end else begin
        next_st.cnt = st.cnt - CW'(1);
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign done = st.done;
endmodule
`default_nettype wire

/* dv/bmpc_core_model.sv */
// Core-side model issuing the deep-sleep choice and wait requests
`timescale 1ns/10ps
`default_nettype none
module bmpc_core_model (
  input wire logic clk_sys,
  input wire logic coreRun,
  input wire logic goDeep,
  input wire logic goWait,
  output logic coreDeepSleep = 1'b0,
  output logic coreWaitReq = 1'b0
);
  // A stopped core cannot execute a wait, so requests are gated by run
  always_ff @(posedge clk_sys) begin
    coreDeepSleep <= goDeep;
    coreWaitReq <= goWait && coreRun;
  end
endmodule
`default_nettype wire

/* dv/bmpc_power_ctrl_props.sv */
// Port assertions for the power controller
`timescale 1ns/10ps
`default_nettype none
module bmpc_power_ctrl_props (
  input wire logic clk_sys,
  input wire logic srst,
  input wire bmpc_pkg::bmpc_req_s regReq,
  input wire logic [bmpc_pkg::DATA_W-1:0] regRdData,
  input wire logic ioRtcWake,
  input wire logic usbEthWake,
  input wire logic coreDeepSleep,
  input wire logic coreWaitReq,
  input wire logic monitorRefOn,
  input wire logic lowIrqReq,
  input wire logic ultralowIrqReq,
  input wire logic nmiReq,
  input wire logic coreRun,
  input wire logic fastClkEn,
  input wire logic mainRegOn,
  input wire logic dcdcEn,
  input wire bmpc_pkg::bmpc_ret_s retention,
  input wire logic wakeGlobalReset
);
  import bmpc_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  property p_rd;
    !regReq.rd |=> regRdData == '0;
  endproperty
  property p_off;
    !monitorRefOn [*3] |-> !lowIrqReq && !ultralowIrqReq && !nmiReq;
  endproperty
  property p_nmi;
    nmiReq |-> !ultralowIrqReq;
  endproperty
  property p_idle;
    coreRun && coreWaitReq && !coreDeepSleep |=> !coreRun && fastClkEn;
  endproperty
  // Set only when the core stops with fast clocks kept, which is idle alone
  logic idleHeld;
  always_ff @(posedge clk_sys) begin
    if (srst || coreRun) begin
      idleHeld <= 1'b0;
    end else if ($fell(coreRun) && fastClkEn) begin
      idleHeld <= 1'b1;
    end
  end
  // Idle wake must not wait on any settle timer
  property p_wake;
    idleHeld && fastClkEn && mainRegOn && (ioRtcWake || usbEthWake) |=> coreRun;
  endproperty
  property p_run;
    $rose(coreRun) |-> fastClkEn && mainRegOn;
  endproperty
  property p_reg;
    !mainRegOn |-> !coreRun && !fastClkEn;
  endproperty
  property p_shut;
    !mainRegOn && !retention.coreKeep |-> !retention.extend;
  endproperty
  property p_grst;
    $rose(wakeGlobalReset) |-> wakeGlobalReset [*4] ##1 !wakeGlobalReset;
  endproperty
  property p_dcdc;
    regReq.wr && regReq.addr == OFS_PWR_PLAN |=> dcdcEn == $past(regReq.wrData[9]);
  endproperty
  a_rd: assert property (p_rd) else $error("read data not cleared");
  a_off: assert property (p_off) else $error("request while disabled");
  a_nmi: assert property (p_nmi) else $error("nmi with plain ultra");
  a_idle: assert property (p_idle) else $error("idle entry wrong");
  a_wake: assert property (p_wake) else $error("idle wake late");
  a_run: assert property (p_run) else $error("core before clock");
  a_reg: assert property (p_reg) else $error("runs without regulator");
  a_shut: assert property (p_shut) else $error("extend kept");
  a_grst: assert property (p_grst) else $error("reset pulse length");
  a_dcdc: assert property (p_dcdc) else $error("dcdc not immediate");
  c_idle: cover property (coreRun && coreWaitReq && !coreDeepSleep);
  c_sleep: cover property (!mainRegOn && retention.coreKeep);
  c_shut: cover property ($rose(wakeGlobalReset));
endmodule
bind bmpc_power_ctrl bmpc_power_ctrl_props uProps (.clk_sys, .srst, .regReq, .regRdData,
  .ioRtcWake, .usbEthWake, .coreDeepSleep, .coreWaitReq, .monitorRefOn, .lowIrqReq,
  .ultralowIrqReq, .nmiReq, .coreRun, .fastClkEn, .mainRegOn, .dcdcEn, .retention,
  .wakeGlobalReset);
`default_nettype wire

/* dv/bmpc_power_ctrl_tb.sv */
// Self-checking bench for the power controller
`timescale 1ns/10ps
`default_nettype none
module bmpc_power_ctrl_tb;
  import bmpc_pkg::*;
  logic clk_sys, srst, battBelowLow, battBelowUltra, ioRtcWake, usbEthWake;
  logic coreDeepSleep, coreWaitReq, goDeep, goWait, irq;
  logic monitorRefOn, lowIrqReq, ultralowIrqReq, nmiReq, coreRun, fastClkEn;
  logic flashStandby, flashOff, mainRegOn, dcdcBias, dcdcEn, wakeGlobalReset;
  logic [1:0] thresholdSelect;
  logic [15:0] regRdData;
  bmpc_req_s regReq;
  bmpc_ret_s retention;
  logic [7:0] ctl [5] = '{8'h01, 8'h09, 8'h05, 8'h0d, 8'h0c};
  logic [2:0] req [5] = '{3'b000, 3'b001, 3'b010, 3'b101, 3'b000};
  int miscompares = 0;
  int nTests = 0;
  int k;

  bmpc_power_ctrl dut (.clk_sys, .srst, .regReq, .regRdData, .battBelowLow, .battBelowUltra,
    .coreDeepSleep, .coreWaitReq, .ioRtcWake, .usbEthWake, .monitorRefOn, .thresholdSelect,
    .lowIrqReq, .ultralowIrqReq, .nmiReq, .irq, .coreRun, .fastClkEn, .flashStandby,
    .flashOff, .mainRegOn, .dcdcBias, .dcdcEn, .retention, .wakeGlobalReset);
  bmpc_core_model coreModel (.clk_sys, .coreRun, .goDeep, .goWait, .coreDeepSleep,
    .coreWaitReq);

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  task automatic check(input string nm, input logic [15:0] s, input logic [15:0] e);
    nTests++;
    if (s !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    regReq.addr <= a;
    regReq.wrData <= d;
    regReq.wr <= 1'b1;
    @(posedge clk_sys);
    regReq.wr <= 1'b0;
    @(negedge clk_sys);
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [15:0] e);
    @(posedge clk_sys);
    regReq.addr <= a;
    regReq.rd <= 1'b1;
    @(posedge clk_sys);
    regReq.rd <= 1'b0;
    @(negedge clk_sys);
    check(nm, regRdData, e);
  endtask
  // Wait request from the core; the model holds the deep-sleep choice
  task automatic enter(input logic d);
    @(posedge clk_sys);
    goDeep <= d;
    goWait <= 1'b1;
    @(posedge clk_sys);
    goWait <= 1'b0;
    cyc(3);
  endtask
  task automatic finishTest();
    $display("comparisons %0d mismatches %0d", nTests, miscompares);
    if (miscompares == 0 && nTests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Whole run is under a thousand cycles; this bound only catches hangs
  initial begin
    repeat (20000) @(posedge clk_sys);
    miscompares++;
    finishTest();
  end

  initial begin
    srst <= 1'b1;
    regReq <= '0;
    {battBelowLow, battBelowUltra, ioRtcWake, usbEthWake, goDeep, goWait} <= '0;
    repeat (3) @(posedge clk_sys);
    srst <= 1'b0;
    cyc(1);
    check("resetOut", {thresholdSelect, coreRun, monitorRefOn}, 4'b0110);
    rdc("ctrl", OFS_MON_CTRL, 16'h0000);
    rdc("plan", OFS_PWR_PLAN, 16'h01df);
    rdc("slpCfg", OFS_SLP_CFG, 16'h0018);
    rdc("mode", OFS_MODE_STAT, 16'h0000);
    rdc("unmapped", 8'h3c, 16'h0000);
    enter(1'b0);
    check("idle", {coreRun, fastClkEn, mainRegOn}, 3'b011);
    @(posedge clk_sys) usbEthWake <= 1'b1;
    @(posedge clk_sys) usbEthWake <= 1'b0;
    @(negedge clk_sys);
    check("idleWake", coreRun, 1'b1);
    @(posedge clk_sys) {battBelowLow, battBelowUltra} <= 2'b11;
    cyc(3);
    rdc("statOff", OFS_MON_STAT, 16'h0000);
    for (int t = 0; t < 4; t++) begin
      wr(OFS_THR_CFG, 16'hfffc | 16'(t));
      rdc("cfg", OFS_THR_CFG, 16'(t));
      check("thrOut", thresholdSelect, 16'(t));
    end
    for (int i = 0; i < 5; i++) begin
      wr(OFS_MON_CTRL, {8'h00, ctl[i] | 8'hf2});
      cyc(3);
      rdc("ctrl", OFS_MON_CTRL, {8'h00, ctl[i]});
      check("ref", monitorRefOn, ctl[i][0]);
      check("req", {nmiReq, ultralowIrqReq, lowIrqReq}, req[i]);
      rdc("stat", OFS_MON_STAT, ctl[i][0] ? 16'h3 : 16'h0);
    end
    wr(OFS_IRQ_STAT, 16'h000f);
    wr(OFS_IRQ_MASK, 16'h0001);
    @(posedge clk_sys) battBelowUltra <= 1'b0;
    wr(OFS_MON_CTRL, 16'h0009);
    cyc(3);
    rdc("lowOnly", OFS_MON_STAT, 16'h0002);
    check("irqSet", irq, 1'b1);
    @(posedge clk_sys) battBelowLow <= 1'b0;
    wr(OFS_IRQ_STAT, 16'h000f);
    cyc(2);
    check("irqClr", irq, 1'b0);
    enter(1'b1);
    check("halt", {coreRun, fastClkEn, mainRegOn, flashOff, flashStandby}, 5'b00110);
    @(posedge clk_sys) battBelowLow <= 1'b1;
    for (k = 0; k < 20 && !fastClkEn; k++) @(negedge clk_sys);
    check("haltClk", {fastClkEn, coreRun}, 2'b10);
    for (k = 0; k < 400 && !coreRun; k++) @(negedge clk_sys);
    check("haltRun", {coreRun, k >= CLK_SETTLE_CYC - 2}, 2'b11);
    @(posedge clk_sys) battBelowLow <= 1'b0;
    wr(OFS_MON_CTRL, 16'h0000);
    wr(OFS_PWR_PLAN, 16'h9616);
    cyc(1);
    check("planHeld", {dcdcBias, dcdcEn, mainRegOn, 6'(retention)}, 9'h1ff);
    enter(1'b1);
    check("sleep", {mainRegOn, coreRun, fastClkEn, 6'(retention)}, 9'h01d);
    @(posedge clk_sys) usbEthWake <= 1'b1;
    @(posedge clk_sys) usbEthWake <= 1'b0;
    cyc(3);
    check("usbIgnored", mainRegOn, 1'b0);
    @(posedge clk_sys) ioRtcWake <= 1'b1;
    @(posedge clk_sys) ioRtcWake <= 1'b0;
    for (k = 0; k < 10 && !mainRegOn; k++) @(negedge clk_sys);
    check("regFirst", {mainRegOn, fastClkEn, coreRun}, 3'b100);
    for (k = 0; k < 700 && !fastClkEn; k++) @(negedge clk_sys);
    check("clkNext", {fastClkEn, coreRun, k >= REG_SETTLE_CYC - 2}, 3'b101);
    for (k = 0; k < 300 && !coreRun; k++) @(negedge clk_sys);
    check("coreLast", {coreRun, k >= CLK_SETTLE_CYC - 2}, 2'b11);
    rdc("planDone", OFS_PWR_PLAN, 16'h1617);
    wr(OFS_PWR_PLAN, 16'h9000);
    enter(1'b1);
    check("shut", {mainRegOn, coreRun, 6'(retention)}, 8'h10);
    @(posedge clk_sys) ioRtcWake <= 1'b1;
    @(posedge clk_sys) ioRtcWake <= 1'b0;
    for (k = 0; k < 10 && !wakeGlobalReset; k++) @(negedge clk_sys);
    check("grst", wakeGlobalReset, 1'b1);
    for (k = 0; k < 1200 && !coreRun; k++) @(negedge clk_sys);
    check("shutRun", coreRun, 1'b1);
    rdc("cause", OFS_RST_CAUSE, 16'h0001);
    rdc("modeRun", OFS_MODE_STAT, 16'h0000);
    enter(1'b0);
    @(posedge clk_sys) srst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    srst <= 1'b0;
    cyc(1);
    check("midReset", {thresholdSelect, coreRun, fastClkEn}, 4'b0111);
    rdc("modeReset", OFS_MODE_STAT, 16'h0000);
    finishTest();
  end
endmodule
`default_nettype wire
